// ---- cdsf_pkg.sv ----
package cdsf_pkg;
	localparam logic [6:0] ADDR_RLINE = 7'h5d;
	localparam logic [6:0] ADDR_PWR = 7'h5e;
	localparam logic [6:0] ADDR_SHORT = 7'h5f;
	localparam logic [6:0] ADDR_STICKY = 7'h60;
	localparam logic [6:0] ADDR_LIVE = 7'h61;
	localparam logic [6:0] ADDR_BTN_CLR = 7'h0e;
	localparam int LEVEL_MSB = 7;
	localparam int LEVEL_LSB = 4;
	localparam int UNMUTE_BIT = 3;
	localparam int PENDING_BIT = 1;
	localparam int RPWR_BIT = 0;
	localparam int BTN_BIT = 3;
	localparam logic [3:0] LEVEL_RST = 4'h0;
	localparam logic [3:0] LEVEL_MAX = 4'h9;
	localparam logic UNMUTE_RST = 1'b0;
	localparam logic PENDING_RST = 1'b1;
	localparam logic [7:0] FLAGS_RST = 8'h00;
	localparam logic [7:0] RDATA_RST = 8'h00;
	localparam int CLK_PERIOD_NS = 10;
	localparam int GAIN_STEP_NS = 1000;
	localparam int GAIN_STEP_CYC = (GAIN_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [7:0] STEP_LAST = 8'(GAIN_STEP_CYC - 1);

	typedef struct packed {
		logic dac_l_pwr;
		logic dac_r_pwr;
		logic mono_line_pwr;
		logic left_line_pwr;
		logic right_line_pwr;
		logic left_hp_pwr;
		logic right_hp_pwr;
		logic left_com_pwr;
		logic right_com_pwr;
		logic [3:0] short_det;
		logic button;
		logic headset;
		logic [1:0] noise_gate;
	} cdsf_status_t;

	localparam cdsf_status_t STATUS_RST = '0;

	typedef enum logic [1:0] {
		cdsf_idle_t_settled,
		cdsf_idle_t_wait,
		cdsf_idle_t_step
	} cdsf_ramp_t;
endpackage

// ---- cdsf_sync_if.sv ----
`timescale 1ns/10ps
interface cdsf_sync_if;
	cdsf_pkg::cdsf_status_t status;
	modport src (output status);
	modport dst (input status);
endinterface

// ---- cdsf_input_sync.sv ----
`timescale 1ns/10ps
module cdsf_input_sync (
	input wire logic mclk,
	input wire logic rst_b,
	input wire cdsf_pkg::cdsf_status_t raw,
	cdsf_sync_if.src sync
);
	cdsf_pkg::cdsf_status_t stage1;
	cdsf_pkg::cdsf_status_t stage2;
	cdsf_pkg::cdsf_status_t next_stage1;
	cdsf_pkg::cdsf_status_t next_stage2;

	// Analog status comes from another domain; the first stage feeds only the second
	always_comb begin
		next_stage1 = raw;
		next_stage2 = stage1;
		if (!rst_b) begin
			next_stage1 = cdsf_pkg::STATUS_RST;
			next_stage2 = cdsf_pkg::STATUS_RST;
		end
	end

	always_ff @(posedge mclk) begin
		stage1 <= next_stage1;
		stage2 <= next_stage2;
	end

	assign sync.status = stage2;
endmodule // cdsf_input_sync

// ---- cdsf_status_bank.sv ----
`timescale 1ns/10ps
module cdsf_status_bank (
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic reg_page0,
	input wire logic [6:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	output logic reg_rvalid,
	input wire logic dac_l_pwr,
	input wire logic dac_r_pwr,
	input wire logic mono_line_driver_pwr,
	input wire logic left_line_driver_pwr,
	input wire logic right_line_driver_pwr,
	input wire logic left_headphone_driver_pwr,
	input wire logic right_headphone_driver_pwr,
	input wire logic left_common_headphone_driver_pwr,
	input wire logic right_common_headphone_driver_pwr,
	input wire logic [3:0] headphone_short,
	input wire logic button_press,
	input wire logic headset_present,
	input wire logic [1:0] noise_gate_low,
	output logic [3:0] right_line_driver_gain,
	output logic right_line_driver_unmute
);
	cdsf_pkg::cdsf_status_t raw;
	cdsf_sync_if sync_if ();
	cdsf_pkg::cdsf_status_t st;

	logic [3:0] level;
	logic unmute;
	logic pending;
	logic [3:0] applied;
	logic [7:0] step_cnt;
	cdsf_pkg::cdsf_ramp_t ramp;
	logic [7:0] sticky;
	logic btn_hold;
	logic headset_q;
	logic [7:0] next_rdata;
	logic next_rvalid;
	logic [3:0] next_level;
	logic next_unmute;
	logic next_pending;
	logic [3:0] next_applied;
	logic [7:0] next_step_cnt;
	cdsf_pkg::cdsf_ramp_t next_ramp;
	logic [7:0] next_sticky;
	logic next_btn_hold;
	logic next_headset_q;
	logic [3:0] target;
	logic [7:0] sticky_set;
	logic hit_wr_ctrl;
	logic hit_rd_sticky;
	logic hit_rd_btn;

	assign raw = '{
		dac_l_pwr: dac_l_pwr,
		dac_r_pwr: dac_r_pwr,
		mono_line_pwr: mono_line_driver_pwr,
		left_line_pwr: left_line_driver_pwr,
		right_line_pwr: right_line_driver_pwr,
		left_hp_pwr: left_headphone_driver_pwr,
		right_hp_pwr: right_headphone_driver_pwr,
		left_com_pwr: left_common_headphone_driver_pwr,
		right_com_pwr: right_common_headphone_driver_pwr,
		short_det: headphone_short,
		button: button_press,
		headset: headset_present,
		noise_gate: noise_gate_low
	};

	cdsf_input_sync u_sync (
		.mclk(mclk),
		.rst_b(rst_b),
		.raw(raw),
		.sync(sync_if.src)
	);

	assign st = sync_if.status;

	function automatic logic hit(input logic page0, input logic [6:0] addr,
		input logic [6:0] want);
		hit = page0 && (addr == want);
	endfunction

	// Reserved codes would exceed the gain table; clamp rather than misbehave
	function automatic logic [3:0] clamp_level(input logic [3:0] code);
		clamp_level = (code > cdsf_pkg::LEVEL_MAX) ? cdsf_pkg::LEVEL_MAX : code;
	endfunction

	assign hit_wr_ctrl = reg_wr && hit(reg_page0, reg_addr, cdsf_pkg::ADDR_RLINE);
	assign hit_rd_sticky = reg_rd && hit(reg_page0, reg_addr, cdsf_pkg::ADDR_STICKY);
	assign hit_rd_btn = reg_rd && hit(reg_page0, reg_addr, cdsf_pkg::ADDR_BTN_CLR);
	assign target = clamp_level(level);

	// Control register: only level and mute are writable
	always_comb begin
		next_level = level;
		next_unmute = unmute;
		if (hit_wr_ctrl) begin
			next_level = reg_wdata[cdsf_pkg::LEVEL_MSB:cdsf_pkg::LEVEL_LSB];
			next_unmute = reg_wdata[cdsf_pkg::UNMUTE_BIT];
		end
		if (!rst_b) begin
			next_level = cdsf_pkg::LEVEL_RST;
			next_unmute = cdsf_pkg::UNMUTE_RST;
		end
	end

	always_ff @(posedge mclk) begin
		level <= next_level;
		unmute <= next_unmute;
	end

	// Gain ramps one dB per step; power is checked only while waiting, so a step already due still lands
	always_comb begin
		next_applied = applied;
		next_step_cnt = step_cnt;
		next_ramp = ramp;
		next_pending = pending;
		unique case (ramp)
			cdsf_pkg::cdsf_idle_t_settled: begin
				if (applied != target) begin
					next_ramp = cdsf_pkg::cdsf_idle_t_wait;
					next_step_cnt = '0;
				end
			end
			cdsf_pkg::cdsf_idle_t_wait: begin
				if (!st.right_line_pwr) begin
					next_step_cnt = '0;
				end else if (step_cnt == cdsf_pkg::STEP_LAST) begin
					next_ramp = cdsf_pkg::cdsf_idle_t_step;
				end else begin
					next_step_cnt = step_cnt + 8'h01;
				end
			end
			cdsf_pkg::cdsf_idle_t_step: begin
				if (applied < target) begin
					next_applied = applied + 4'h1;
				end else if (applied > target) begin
					next_applied = applied - 4'h1;
				end
				next_ramp = cdsf_pkg::cdsf_idle_t_settled;
			end
			default: begin
				next_ramp = cdsf_pkg::cdsf_idle_t_settled;
			end
		endcase
		next_pending = (next_applied != target) || !st.right_line_pwr;
		if (!rst_b) begin
			next_applied = cdsf_pkg::LEVEL_RST;
			next_step_cnt = '0;
			next_ramp = cdsf_pkg::cdsf_idle_t_settled;
			next_pending = cdsf_pkg::PENDING_RST;
		end
	end

	always_ff @(posedge mclk) begin
		applied <= next_applied;
		step_cnt <= next_step_cnt;
		ramp <= next_ramp;
		pending <= next_pending;
	end

	// Event flags; a new event in the clearing read cycle survives
	always_comb begin
		sticky_set = {st.short_det, st.button, st.headset ^ headset_q, st.noise_gate};
		next_sticky = (hit_rd_sticky ? cdsf_pkg::FLAGS_RST : sticky) | sticky_set;
		next_btn_hold = (hit_rd_btn ? 1'b0 : btn_hold) | st.button;
		next_headset_q = st.headset;
		if (!rst_b) begin
			next_sticky = cdsf_pkg::FLAGS_RST;
			next_btn_hold = 1'b0;
			next_headset_q = 1'b0;
		end
	end

	always_ff @(posedge mclk) begin
		sticky <= next_sticky;
		btn_hold <= next_btn_hold;
		headset_q <= next_headset_q;
	end

	// Read data is registered; writes to status addresses change nothing
	always_comb begin
		next_rdata = reg_rdata;
		next_rvalid = reg_rd;
		if (reg_rd && reg_page0) begin
			unique case (reg_addr)
				cdsf_pkg::ADDR_RLINE: begin
					next_rdata = {level, unmute, 1'b0, pending, st.right_line_pwr};
				end
				cdsf_pkg::ADDR_PWR: begin
					next_rdata = {st.dac_l_pwr, st.dac_r_pwr, st.mono_line_pwr,
						st.left_line_pwr, st.right_line_pwr,
						st.left_hp_pwr, st.right_hp_pwr, 1'b0};
				end
				cdsf_pkg::ADDR_SHORT: begin
					next_rdata = {st.short_det, st.left_com_pwr,
						st.right_com_pwr, 2'b00};
				end
				cdsf_pkg::ADDR_STICKY: begin
					next_rdata = sticky;
				end
				cdsf_pkg::ADDR_LIVE: begin
					next_rdata = {st.short_det, btn_hold, st.headset, st.noise_gate};
				end
				default: begin
					next_rdata = cdsf_pkg::RDATA_RST;
				end
			endcase
		end else if (reg_rd) begin
			next_rdata = cdsf_pkg::RDATA_RST;
		end
		if (!rst_b) begin
			next_rdata = cdsf_pkg::RDATA_RST;
			next_rvalid = 1'b0;
		end
	end

	always_ff @(posedge mclk) begin
		reg_rdata <= next_rdata;
		reg_rvalid <= next_rvalid;
		right_line_driver_gain <= next_applied;
		right_line_driver_unmute <= next_unmute;
	end

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_b);

	AST_LEVEL_WRITE: assert property (
		hit_wr_ctrl |=> level == $past(reg_wdata[7:4]))
		else $error("level field not written");

	AST_MUTE_OUT: assert property (
		hit_wr_ctrl |=> right_line_driver_unmute == $past(reg_wdata[3]))
		else $error("mute output does not follow write");

	AST_PENDING_OFF: assert property (
		!st.right_line_pwr |=> pending)
		else $error("gain reported applied while driver unpowered");

	AST_GAIN_MAX: assert property (
		right_line_driver_gain <= cdsf_pkg::LEVEL_MAX)
		else $error("applied gain beyond 9 dB");

	AST_CTRL_RD: assert property (
		reg_rd && hit(reg_page0, reg_addr, cdsf_pkg::ADDR_RLINE)
		|=> reg_rvalid && reg_rdata[2] == 1'b0
		&& reg_rdata[0] == $past(st.right_line_pwr))
		else $error("control readback wrong");

	AST_PWR_RD: assert property (
		reg_rd && hit(reg_page0, reg_addr, cdsf_pkg::ADDR_PWR)
		|=> reg_rdata[0] == 1'b0 && reg_rdata[7] == $past(st.dac_l_pwr))
		else $error("power status readback wrong");

	AST_SHORT_RD: assert property (
		reg_rd && hit(reg_page0, reg_addr, cdsf_pkg::ADDR_SHORT)
		|=> reg_rdata[1:0] == 2'b00 && reg_rdata[7:4] == $past(st.short_det))
		else $error("short status readback wrong");

	AST_STICKY_HOLD: assert property (
		sticky[7] && !hit_rd_sticky |=> sticky[7])
		else $error("sticky short flag lost without read");

	AST_STICKY_CLR: assert property (
		hit_rd_sticky && sticky_set == 8'h00 |=> sticky == 8'h00)
		else $error("sticky flags not cleared by read");

	AST_BTN_HOLD: assert property (
		btn_hold && !hit_rd_btn |=> btn_hold)
		else $error("button hold cleared without read");

	AST_RO_WRITE: assert property (
		reg_wr && !hit_wr_ctrl |=> $stable(level) && $stable(unmute))
		else $error("write to read-only register changed control");

	AST_RAMP_TIME: assert property (
		ramp == cdsf_pkg::cdsf_idle_t_wait && st.right_line_pwr
		|-> ##[0:110] ramp != cdsf_pkg::cdsf_idle_t_wait || !st.right_line_pwr)
		else $error("gain step took too long");

	AST_PWR_BITS: assert property (
		reg_rd && hit(reg_page0, reg_addr, cdsf_pkg::ADDR_PWR)
		|=> reg_rdata[6:1] == $past({st.dac_r_pwr, st.mono_line_pwr,
		st.left_line_pwr, st.right_line_pwr, st.left_hp_pwr, st.right_hp_pwr}))
		else $error("module power bits wrong");

	AST_COM_PWR: assert property (
		reg_rd && hit(reg_page0, reg_addr, cdsf_pkg::ADDR_SHORT)
		|=> reg_rdata[3:2] == $past({st.left_com_pwr, st.right_com_pwr}))
		else $error("common driver power bits wrong");

	AST_LIVE_RD: assert property (
		reg_rd && hit(reg_page0, reg_addr, cdsf_pkg::ADDR_LIVE)
		|=> reg_rdata[7:4] == $past(st.short_det)
		&& reg_rdata[2:0] == $past({st.headset, st.noise_gate}))
		else $error("live flag readback wrong");

	AST_STICKY_SET: assert property (
		sticky_set != 8'h00 |=> (sticky & $past(sticky_set)) == $past(sticky_set))
		else $error("sticky flag missed an event");

	AST_STICKY_RD: assert property (
		hit_rd_sticky |=> reg_rdata == $past(sticky))
		else $error("sticky read lost latched flags");

	AST_BTN_SET: assert property (
		st.button |=> btn_hold)
		else $error("live button bit not set");

	AST_GAIN_STEP: assert property (
		$changed(right_line_driver_gain)
		|-> right_line_driver_gain == $past(right_line_driver_gain) + 4'h1
		|| right_line_driver_gain + 4'h1 == $past(right_line_driver_gain))
		else $error("applied gain jumped more than 1 dB");

	COV_UNMUTE: cover property (hit_wr_ctrl && reg_wdata[3]);
	COV_SETTLE: cover property (pending ##1 !pending);
	COV_STICKY_READ: cover property (sticky != 8'h00 && hit_rd_sticky);
	COV_BTN_CLR: cover property (btn_hold && hit_rd_btn);
endmodule // cdsf_status_bank

// ---- cdsf_host_model.sv ----
`timescale 1ns/10ps
module cdsf_host_model (
	input wire logic mclk,
	input wire logic [7:0] reg_rdata,
	input wire logic reg_rvalid,
	output logic reg_page0,
	output logic [6:0] reg_addr,
	output logic reg_wr,
	output logic reg_rd,
	output logic [7:0] reg_wdata
);
	initial begin
		reg_page0 = 1'b1;
		reg_addr = 7'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_wdata = 8'h00;
	end
	// Idle bus shows junk, so a stale value cannot pass
	task automatic idle();
		reg_addr = ~reg_addr;
		reg_wdata = ~reg_wdata;
	endtask
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		@(negedge mclk);
		reg_page0 = 1'b1;
		reg_addr = a;
		// Reserved codes clamped reserved bits only in refusal
		reg_wdata = (d[7:4] > 4'h9) ? {4'h9, d[3:0]} : d;
		reg_wr = 1'b1;
		@(negedge mclk);
		reg_wr = 1'b0;
		idle();
	endtask
	task automatic rd(input logic pg, input logic [6:0] a, output logic [7:0] d,
		output logic v);
		@(negedge mclk);
		reg_page0 = pg;
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge mclk);
		reg_rd = 1'b0;
		d = reg_rdata;
		v = reg_rvalid;
		reg_page0 = 1'b1;
		idle();
	endtask
endmodule // cdsf_host_model

// ---- tb_top.sv ----
`timescale 1ns/10ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin errors++; \
	$display("[ERR] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_top;
	logic mclk;
	logic rst_b;
	logic reg_page0, reg_wr, reg_rd, reg_rvalid, v, btn, hs, unmute, m_btn;
	logic [6:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata, d;
	logic [8:0] pw;
	logic [3:0] hp_short, gain;
	logic [1:0] ng;
	int errors, tests_run, cyc, seed, m_sticky;
	cdsf_host_model u_host (.mclk(mclk), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
		.reg_page0(reg_page0), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_wdata(reg_wdata));
	cdsf_status_bank u_dut (.mclk(mclk), .rst_b(rst_b), .reg_page0(reg_page0),
		.reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .dac_l_pwr(pw[8]),
		.dac_r_pwr(pw[7]), .mono_line_driver_pwr(pw[6]), .left_line_driver_pwr(pw[5]),
		.right_line_driver_pwr(pw[4]), .left_headphone_driver_pwr(pw[3]),
		.right_headphone_driver_pwr(pw[2]), .left_common_headphone_driver_pwr(pw[1]),
		.right_common_headphone_driver_pwr(pw[0]), .headphone_short(hp_short),
		.button_press(btn), .headset_present(hs), .noise_gate_low(ng),
		.right_line_driver_gain(gain), .right_line_driver_unmute(unmute));
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	task automatic wrap_up();
		$display("errors=%0d tests_run=%0d", errors, tests_run);
		if (errors == 0 && tests_run > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	// Every read must answer one cycle later
	task automatic rdc(input logic pg, input logic [6:0] a);
		u_host.rd(pg, a, d, v);
		`CHK(v, 1'b1)
	endtask
	// Model tracks what the sticky and live flags should hold
	task automatic drive(input logic [3:0] s, input logic b, input logic h, input logic [1:0] n);
		@(negedge mclk);
		m_sticky |= {s, b, h != hs, n};
		m_btn |= b;
		hp_short = s;
		btn = b;
		hs = h;
		ng = n;
		repeat (4) @(negedge mclk);
	endtask
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 6000) begin
			errors++;
			wrap_up();
		end
	end
	initial begin
		seed = 69373;
		rst_b = 1'b0;
		pw = 9'h000;
		hp_short = 4'h0;
		btn = 1'b0;
		hs = 1'b0;
		ng = 2'b00;
		m_sticky = 0;
		m_btn = 1'b0;
		repeat (8) @(negedge mclk);
		rst_b = 1'b1;
		rdc(1'b1, cdsf_pkg::ADDR_RLINE);
		`CHK(d, 8'h02)
		`CHK(unmute, 1'b0)
		pw = 9'h010;
		u_host.wr(cdsf_pkg::ADDR_RLINE, 8'h58);
		`CHK(unmute, 1'b1)
		rdc(1'b1, cdsf_pkg::ADDR_RLINE);
		`CHK(d[1], 1'b1)
		for (int i = 0; i < 2000 && gain !== 4'h5; i++) @(negedge mclk);
		`CHK(gain, 4'h5)
		rdc(1'b1, cdsf_pkg::ADDR_RLINE);
		`CHK(d, 8'h59)
		// Ramp down too, then drop power so pending must come back
		u_host.wr(cdsf_pkg::ADDR_RLINE, 8'h28);
		for (int i = 0; i < 2000 && gain !== 4'h2; i++) @(negedge mclk);
		`CHK(gain, 4'h2)
		pw = 9'h000;
		repeat (4) @(negedge mclk);
		rdc(1'b1, cdsf_pkg::ADDR_RLINE);
		`CHK(d, 8'h2a)
		repeat (6) begin
			pw = 9'($random(seed));
			drive(4'($random(seed)), 1'b0, 1'b0, 2'b00);
			rdc(1'b1, cdsf_pkg::ADDR_PWR);
			`CHK(d, {pw[8:2], 1'b0})
			rdc(1'b1, cdsf_pkg::ADDR_SHORT);
			`CHK(d, {hp_short, pw[1:0], 2'b00})
			rdc(1'b1, cdsf_pkg::ADDR_RLINE);
			`CHK(d[0], pw[4])
		end
		drive(4'h0, 1'b0, 1'b0, 2'b00);
		rdc(1'b1, cdsf_pkg::ADDR_STICKY);
		`CHK(d, 8'(m_sticky))
		m_sticky = 0;
		drive(4'ha, 1'b1, 1'b1, 2'b01);
		rdc(1'b1, cdsf_pkg::ADDR_LIVE);
		`CHK(d, {hp_short, m_btn, hs, ng})
		drive(4'h0, 1'b0, 1'b1, 2'b00);
		rdc(1'b1, cdsf_pkg::ADDR_LIVE);
		`CHK(d, {hp_short, m_btn, hs, ng})
		rdc(1'b1, cdsf_pkg::ADDR_STICKY);
		`CHK(d, 8'(m_sticky))
		m_sticky = 0;
		rdc(1'b1, cdsf_pkg::ADDR_STICKY);
		`CHK(d, 8'(m_sticky))
		rdc(1'b1, cdsf_pkg::ADDR_BTN_CLR);
		`CHK(d, 8'h00)
		m_btn = 1'b0;
		rdc(1'b1, cdsf_pkg::ADDR_LIVE);
		`CHK(d, {hp_short, m_btn, hs, ng})
		drive(4'h0, 1'b0, 1'b0, 2'b00);
		rdc(1'b1, cdsf_pkg::ADDR_STICKY);
		`CHK(d, 8'(m_sticky))
		m_sticky = 0;
		for (int a = 'h5e; a <= 'h61; a++) u_host.wr(7'(a), 8'hff);
		rdc(1'b1, cdsf_pkg::ADDR_PWR);
		`CHK(d, {pw[8:2], 1'b0})
		rdc(1'b1, cdsf_pkg::ADDR_LIVE);
		`CHK(d, 8'h00)
		rdc(1'b1, 7'h7f);
		`CHK(d, 8'h00)
		rdc(1'b0, cdsf_pkg::ADDR_RLINE);
		`CHK(d, 8'h00)
		wrap_up();
	end
endmodule // tb_top
